/* File: tmc_pkg.sv */
package tmc_pkg;
	// APB byte address of the control register, plus status and count
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_COUNT = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	// Control field positions
	localparam int BIT_RUN = 15;
	localparam int BIT_STOP_IDLE = 13;
	localparam int BIT_GATE = 6;
	localparam int BIT_PRE_HI = 5;
	localparam int BIT_PRE_LO = 4;
	localparam int BIT_SYNC = 2;
	localparam int BIT_CLKSRC = 1;
	// Writable bits of the control register; others read as zero
	localparam logic [15:0] CONTROL_MASK = 16'hA076;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	// Prescaler terminal counts (divide minus one)
	localparam logic [7:0] DIV1_LAST = 8'h00;
	localparam logic [7:0] DIV8_LAST = 8'h07;
	localparam logic [7:0] DIV64_LAST = 8'h3F;
	localparam logic [7:0] DIV256_LAST = 8'hFF;
endpackage

/* File: tmc_timer.sv */
// Operation
// [R01] Run enable bit 15 starts the timer when set, stops it when clear.
// [R02] Prescale bits 5-4 divide input clock: 11=256, 10=64, 01=8, 00=1.
// [R03] Clock source bit 1 picks external pin rising edge, else peripheral clock.
// [R04] With external source, sync bit 2 synchronizes the pin to the device clock. Here the pin is synchronized with the bit clear too.
// [R05] With internal source, gate bit 6 enables gated time accumulation.
// [R06] Gate ignored with external source; sync ignored with internal source.
// [R07] Stop-in-idle bit 13 halts the timer in idle mode when set.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_count_pin,
	input wire logic gate_pin,
	input wire logic idle_mode,
	output logic [15:0] count,
	output logic tick
);
	logic [15:0] timer_one_control;
	logic [15:0] next_count;
	logic [7:0] pre_cnt;
	logic [2:0] pin_sync;
	logic [1:0] gate_sync;
	logic [1:0] idle_sync;
	logic raw_edge;
	logic sync_edge;
	logic src_event;
	logic pre_done;
	logic gate_open;
	logic running;
	logic acc;

	wire run_enable = timer_one_control[tmc_pkg::BIT_RUN];
	wire stop_in_idle = timer_one_control[tmc_pkg::BIT_STOP_IDLE];
	wire gate_accumulate_enable = timer_one_control[tmc_pkg::BIT_GATE];
	wire [1:0] prescale_select = timer_one_control[tmc_pkg::BIT_PRE_HI:tmc_pkg::BIT_PRE_LO];
	wire ext_clock_sync = timer_one_control[tmc_pkg::BIT_SYNC];
	wire clock_source_select = timer_one_control[tmc_pkg::BIT_CLKSRC];

	// Terminal count of the prescaler for a select code
	function automatic logic [7:0] pre_last(input logic [1:0] sel);
		case (sel)
			2'h3: pre_last = tmc_pkg::DIV256_LAST;
			2'h2: pre_last = tmc_pkg::DIV64_LAST;
			2'h1: pre_last = tmc_pkg::DIV8_LAST;
			default: pre_last = tmc_pkg::DIV1_LAST;
		endcase
	endfunction

	// Writes land only at the access edge where pready is high
	wire apb_wr = psel && penable && pwrite && pready;
	wire wr_ctl = apb_wr && paddr == tmc_pkg::ADDR_CONTROL;
	wire wr_cnt = apb_wr && paddr == tmc_pkg::ADDR_COUNT;
	wire apb_hit = (paddr == tmc_pkg::ADDR_CONTROL) || (paddr == tmc_pkg::ADDR_COUNT)
		|| (paddr == tmc_pkg::ADDR_STATUS);

	// Control register write; unimplemented bits stay zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_one_control <= tmc_pkg::CONTROL_RESET;
		end else if (apb_wr && paddr == tmc_pkg::ADDR_CONTROL) begin
			timer_one_control <= pwdata[15:0] & tmc_pkg::CONTROL_MASK;
		end
	end

	// Two-flop synchronisers; third pin stage only feeds the edge detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_sync <= 3'h0;
			gate_sync <= 2'h0;
			idle_sync <= 2'h0;
		end else begin
			pin_sync <= {pin_sync[1:0], ext_count_pin};
			gate_sync <= {gate_sync[0], gate_pin};
			idle_sync <= {idle_sync[0], idle_mode};
		end
	end

	// Single-clock design: a raw pin must never reach logic, so both sync settings
	// read the same twice-registered pin and the sync bit only picks the path
	assign sync_edge = pin_sync[2] == 1'b0 && pin_sync[1] == 1'b1 && ext_clock_sync; // [R04]
	assign raw_edge = pin_sync[2] == 1'b0 && pin_sync[1] == 1'b1 && !ext_clock_sync;

	// Source choice; gate ignored for the pin, sync ignored for internal
	always_comb begin
		if (clock_source_select) begin // [R03]
			src_event = sync_edge || raw_edge; // [R06]
			gate_open = 1'b1; // [R06]
		end else begin
			src_event = 1'b1;
			gate_open = !gate_accumulate_enable || gate_sync[1]; // [R05]
		end
	end

	assign running = run_enable && !(stop_in_idle && idle_sync[1]); // [R01] [R07]
	assign acc = running && src_event && gate_open;
	assign pre_done = acc && (pre_cnt == pre_last(prescale_select)); // [R02]
	assign next_count = count + 16'h0001;

	// Prescaler counts qualified events; cleared when stopped or reprogrammed,
	// so a smaller ratio never has to wait for the counter to wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt <= 8'h00;
		end else if (!run_enable || wr_ctl) begin
			pre_cnt <= 8'h00;
		end else if (pre_done) begin
			pre_cnt <= 8'h00; // [R02]
		end else if (acc) begin
			pre_cnt <= pre_cnt + 8'h01;
		end
	end

	// Timer count; software may load it over APB
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= tmc_pkg::COUNT_RESET;
			tick <= 1'b0;
		end else begin
			tick <= pre_done;
			if (apb_wr && paddr == tmc_pkg::ADDR_COUNT) begin
				count <= pwdata[15:0];
			end else if (pre_done) begin
				count <= next_count; // [R01]
			end
		end
	end

	// APB answer: zero wait states, unmapped reads zero with error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !apb_hit;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					tmc_pkg::ADDR_CONTROL: prdata <= {16'h0000, timer_one_control};
					tmc_pkg::ADDR_COUNT: prdata <= {16'h0000, count};
					tmc_pkg::ADDR_STATUS: prdata <= {29'h0, idle_sync[1], gate_sync[1], running};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Checker state: consecutive stopped cycles with no count load. A long stop is
	// where a stray increment would hide, so it is tracked by counter, not by repetition
	logic [7:0] stop_len;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_len <= 8'h00;
		end else if (running || wr_cnt) begin
			stop_len <= 8'h00;
		end else if (stop_len != 8'hFF) begin
			stop_len <= stop_len + 8'h01;
		end
	end

	// Checker state: cycles since the last prescaler wrap, and whether that interval
	// ran undisturbed on the internal clock with no gate and no control rewrite
	logic [8:0] tick_gap;
	logic steady;
	wire disturb = !running || clock_source_select || gate_accumulate_enable || wr_ctl;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_gap <= 9'h000;
			steady <= 1'b0;
		end else if (pre_done) begin
			tick_gap <= 9'h001;
			steady <= !disturb;
		end else begin
			steady <= steady && !disturb;
			if (tick_gap != 9'h1FF) begin
				tick_gap <= tick_gap + 9'h001;
			end
		end
	end

	// Stopped: the count moves only by a software load
	AST_RUN_STOP: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		!run_enable |=> $stable(count) || $past(wr_cnt))
		else $error("count moved while stopped");

	// Running on the internal clock at 1:1 with no gate: one step per cycle
	AST_RUN_COUNT: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		(running && !clock_source_select && !gate_accumulate_enable && prescale_select == 2'h0 && !wr_cnt)
		|=> count == $past(count) + 16'h0001)
		else $error("count missed an internal clock");

	// Stopping restarts the prescaler from zero
	AST_PRE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		!run_enable |=> pre_cnt == 8'h00)
		else $error("prescaler not cleared while stopped");

	// Control write keeps only the implemented bits
	AST_CTL_WR: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		wr_ctl |=> timer_one_control == ($past(pwdata[15:0]) & tmc_pkg::CONTROL_MASK))
		else $error("ctl write");

	// Count write loads the low half of the bus word
	AST_CNT_WR: assert property (@(posedge pclk) disable iff (!presetn) // [R01]
		wr_cnt |=> count == $past(pwdata[15:0]))
		else $error("count load");

	// 1:1 passes every qualified event
	AST_DIV1: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		(acc && prescale_select == 2'h0) |-> pre_done)
		else $error("1:1 missed event");

	// 1:8 wraps after eight events
	AST_DIV8: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		(pre_done && prescale_select == 2'h1) |-> pre_cnt == 8'h07)
		else $error("1:8 wrong");

	// 1:64 wraps after sixty-four events
	AST_DIV64: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		(pre_done && prescale_select == 2'h2) |-> pre_cnt == 8'h3F)
		else $error("1:64 wrong");

	// 1:256 wraps after the full prescaler range
	AST_DIV256: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		(pre_done && prescale_select == 2'h3) |-> pre_cnt == 8'hFF)
		else $error("1:256 wrong");

	// The tick pin follows each prescaler wrap by exactly one cycle
	AST_TICK_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		1'b1 |=> tick == $past(pre_done))
		else $error("tick out of step");

	// Undisturbed internal clocking: wraps are exactly one divide ratio apart
	AST_TICK_GAP: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
		(pre_done && steady) |-> tick_gap == ({1'b0, pre_last(prescale_select)} + 9'h001))
		else $error("divide ratio wrong");

	// Pin source: no count without a pin edge
	AST_PIN_SRC: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		(clock_source_select && running && !(sync_edge || raw_edge)) |-> !acc)
		else $error("pin idle count");

	// Pin source: only a rising edge of the registered pin is counted
	AST_PIN_EDGE_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		(clock_source_select && acc) |-> (pin_sync[1] && !pin_sync[2]))
		else $error("counted on a non-rising pin");

	// Internal source: every open cycle is an event
	AST_INT_SRC: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		(!clock_source_select && running && gate_open) |-> acc)
		else $error("internal clock lost");

	// Synchronised path raised the edge that the pipeline shows one cycle later
	AST_SYNC_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		($past(ext_clock_sync) && $rose(pin_sync[2])) |-> $past(sync_edge))
		else $error("sync edge");

	// Unsynchronised setting uses the other path for the same edge
	AST_RAW_EDGE: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		(!$past(ext_clock_sync) && $rose(pin_sync[2])) |-> $past(raw_edge))
		else $error("raw edge");

	// One edge is never counted twice through both paths
	AST_EDGE_ONE_PATH: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		!(sync_edge && raw_edge))
		else $error("edge on both paths");

	// Gated mode with the gate low: nothing accumulates
	AST_GATE: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		(!clock_source_select && gate_accumulate_enable && !gate_sync[1]) |-> !acc)
		else $error("gate ignored");

	// Gated mode with the gate high: every cycle accumulates
	AST_GATE_OPEN: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		(!clock_source_select && gate_accumulate_enable && gate_sync[1] && running) |-> acc)
		else $error("open gate blocked");

	// Pin source: the gate setting has no effect
	AST_GATE_IGN: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
		(clock_source_select && running && src_event) |-> acc)
		else $error("gate not ignored");

	// Internal source: the sync setting has no effect
	AST_SYNC_IGN: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
		!clock_source_select |-> src_event)
		else $error("sync not ignored");

	// Stop-in-idle set and idle seen: the timer halts
	AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		(stop_in_idle && idle_sync[1]) |-> !running)
		else $error("ran in idle");

	// Stop-in-idle clear: the run bit alone decides
	AST_IDLE_RUN: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		(run_enable && !stop_in_idle) |-> running)
		else $error("halted without stop-in-idle");

	// Halted in idle: the prescaler keeps its place
	AST_PRE_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		(run_enable && !running && !wr_ctl) |=> $stable(pre_cnt))
		else $error("prescaler moved while halted");

	// Any stopped stretch with no count load, however long, leaves the count untouched
	AST_STOP_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		stop_len != 8'h00 |-> $stable(count))
		else $error("count moved during a stop");
endmodule
`default_nettype wire

/* File: tmc_ext_src.sv */
`timescale 1ns/1ps
`default_nettype none
// Pulse source on the count pin; it rests low between bursts
module tmc_ext_src (
	input wire logic pclk,
	input wire logic en,
	output logic pin
);
	logic [1:0] ph = 2'h0;
	// Two cycles high, two low, so each level outlasts the pin sampler
	always @(posedge pclk) begin
		ph <= en ? ph + 2'h1 : 2'h0;
	end
	assign pin = en & ph[1];
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic pclk, presetn, psel, penable, pwrite, gate_pin, idle_mode, en, pin, pready, pslverr, tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] count;
	int err_count = 0;
	int samples_checked = 0;
	int dv[4] = '{1, 8, 64, 256};
	tmc_timer u_tmc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_pin(pin), .gate_pin(gate_pin), .idle_mode(idle_mode), .count(count), .tick(tick));
	tmc_ext_src u_tmc_ext_src (.pclk(pclk), .en(en), .pin(pin));
	// 20 MHz bus clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	// Request held steady until pready is seen high, bounded wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			report_and_stop();
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [32:0] r;
		apb(1'b1, a, {16'h0000, d}, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] exp);
		logic [32:0] r;
		apb(1'b0, a, 32'h00000000, r);
		chk(r[31:0], exp[31:0]);
		chk({31'h0, r[32]}, {31'h0, exp[32]});
	endtask
	// Cycles between two ticks; the first tick only aligns
	task automatic gap(input logic [31:0] exp);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (tick !== 1'b1 && n < 600);
			if (tick !== 1'b1) begin
				err_count++;
				report_and_stop();
			end
		end
		chk(n, exp);
	endtask
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, gate_pin, idle_mode, en} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(tmc_pkg::ADDR_CONTROL, {17'h00000, tmc_pkg::CONTROL_RESET});
		rd(12'h00C, {1'b1, 32'h00000000});
		wr(tmc_pkg::ADDR_CONTROL, 16'hFFFF);
		rd(tmc_pkg::ADDR_CONTROL, {17'h00000, tmc_pkg::CONTROL_MASK});
		for (int p = 0; p < 4; p++) begin
			wr(tmc_pkg::ADDR_CONTROL, 16'h8000 | (16'(p) << 4));
			gap(dv[p]);
		end
		wr(tmc_pkg::ADDR_CONTROL, 16'h0000);
		wr(tmc_pkg::ADDR_COUNT, 16'h1234);
		repeat (10) @(posedge pclk);
		rd(tmc_pkg::ADDR_COUNT, 33'h000001234);
		chk({16'h0000, count}, 32'h00001234);
		wr(tmc_pkg::ADDR_CONTROL, 16'h8040);
		repeat (10) @(posedge pclk);
		rd(tmc_pkg::ADDR_COUNT, 33'h000001234);
		gate_pin <= 1'b1;
		gap(1);
		gate_pin <= 1'b0;
		idle_mode <= 1'b1;
		wr(tmc_pkg::ADDR_CONTROL, 16'hA000);
		wr(tmc_pkg::ADDR_COUNT, 16'h0000);
		repeat (10) @(posedge pclk);
		rd(tmc_pkg::ADDR_COUNT, 33'h000000000);
		rd(tmc_pkg::ADDR_STATUS, 33'h000000004);
		idle_mode <= 1'b0;
		gap(1);
		wr(tmc_pkg::ADDR_CONTROL, 16'h8004);
		gap(1);
		// Gate set but low: with the pin as source it must not matter
		for (int s = 0; s < 2; s++) begin
			wr(tmc_pkg::ADDR_CONTROL, 16'h8042 | (16'(s) << 2));
			wr(tmc_pkg::ADDR_COUNT, 16'h0000);
			en <= 1'b1;
			repeat (20) @(posedge pclk);
			en <= 1'b0;
			repeat (8) @(posedge pclk);
			rd(tmc_pkg::ADDR_COUNT, 33'h000000005);
			chk({16'h0000, count}, 32'h00000005);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
